// *** pkg/dass_pkg.sv ***
// Purpose: shared constants and types for the debug access status block
// Assumes: 8-bit access-layer register space, byte-wide data
// Notes:   offsets are byte addresses in that space
package dass_pkg;

  // register offsets
  localparam logic [7:0] RESET_REQ_OFFSET    = 8'h08;
  localparam logic [7:0] SYS_CONTROL_OFFSET  = 8'h0A;
  localparam logic [7:0] SYS_STATUS_OFFSET   = 8'h0B;
  localparam logic [7:0] CRC_STATUS_OFFSET   = 8'h0C;

  // field positions
  localparam int RESET_ACTIVE_BIT  = 5;
  localparam int ASLEEP_BIT        = 4;
  localparam int NVM_READY_BIT     = 3;
  localparam int UROW_READY_BIT    = 2;
  localparam int LOCKED_BIT        = 0;
  localparam int UROW_DONE_BIT     = 1;
  localparam int RESET_REQ_BIT     = 0;

  // reset values and codes
  localparam logic [7:0] SYS_STATUS_RESET  = 8'h01;
  localparam logic [7:0] CRC_STATUS_RESET  = 8'h00;
  localparam logic [7:0] RESET_SIGNATURE   = 8'h59;
  localparam logic [2:0] CRC_OFF           = 3'h0;
  localparam logic [2:0] CRC_BUSY          = 3'h1;
  localparam logic [2:0] CRC_GOOD          = 3'h2;
  localparam logic [2:0] CRC_FAIL          = 3'h4;

  // sleep depth reported by the system domain
  typedef enum logic [1:0] {
    DASS_ACTIVE  = 2'b00,
    DASS_IDLE    = 2'b01,
    DASS_STANDBY = 2'b10,
    DASS_PDOWN   = 2'b11
  } dass_sleep_t;

  // status arriving from the system domain
  typedef struct packed {
    logic        in_reset;
    dass_sleep_t sleep_mode;
    logic        nvm_program_ready;
    logic        user_row_program_ready;
    logic        device_locked;
    logic        crc_enabled;
    logic        crc_busy;
    logic        crc_pass;
  } dass_sys_t;

  // access-layer register bus
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dass_acc_t;

endpackage : dass_pkg

// *** rtl/dass_status.sv ***
// Purpose: access-layer status registers of the single-wire debug interface
// Assumes: system status inputs already synchronous to clock
// Notes:   read data registered, one cycle after the read strobe
//          writes to the two status offsets are ignored
//
// Contract
// - reset-active flag follows system reset
// - status read clears reset-active flag unless a reset is live
// - debugger reset request also sets flag
// - asleep flag set for idle or deeper
// - nvm-ready flag tells debugger to program
// - user-row-ready flag permits user row programming
// - locked flag mirrors sys.device_locked, no reset value of its own
// - locked clears after erase and unlock
// - crc status one-hot in bits 2:0, all zero when off
// - signature write resets system, other releases
// - user-row-done starts flash write, key gated
`timescale 1ns/100ps
`default_nettype none

module dass_status (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // access-layer register port
  input  wire dass_pkg::dass_acc_t acc,
  output logic [7:0]            rdata,
  output logic                  rvalid,
  // system domain status
  input  wire dass_pkg::dass_sys_t sys,
  input  wire logic             user_row_key_ok,
  // system domain control
  output logic                  system_reset_request,
  output logic                  user_row_write_done
);

  // registered state and next values
  logic       reset_seen_reg;
  logic       reset_seen_next;
  logic       reset_req_reg;
  logic       reset_req_next;
  logic       done_reg;
  logic       done_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;

  // decoded strobes
  logic       status_read;
  logic       reset_req_write;
  logic       control_write;
  logic       signature_match;
  logic       reset_live;

  // read views
  logic [2:0] crc_code;
  logic [7:0] status_view;
  logic [7:0] crc_view;
  logic [7:0] reset_req_view;

  // read strobe aimed at one offset
  function automatic logic read_hit(
    input dass_pkg::dass_acc_t a,
    input logic [7:0]          offset
  );
    read_hit = a.rd && (a.addr == offset);
  endfunction : read_hit

  // write strobe aimed at one offset
  function automatic logic write_hit(
    input dass_pkg::dass_acc_t a,
    input logic [7:0]          offset
  );
    write_hit = a.wr && (a.addr == offset);
  endfunction : write_hit

  // idle and every deeper mode count as asleep
  function automatic logic asleep(input dass_pkg::dass_sleep_t mode);
    asleep = 1'h1;
    unique case (mode)
      dass_pkg::DASS_ACTIVE:  asleep = 1'h0;
      dass_pkg::DASS_IDLE:    asleep = 1'h1;
      dass_pkg::DASS_STANDBY: asleep = 1'h1;
      dass_pkg::DASS_PDOWN:   asleep = 1'h1;
    endcase
  endfunction : asleep

  // one-hot scan result, all zero when off; a finished scan is good or failed, never both
  function automatic logic [2:0] crc_encode(input dass_pkg::dass_sys_t s);
    if (!s.crc_enabled) begin
      crc_encode = dass_pkg::CRC_OFF;
    end else if (s.crc_busy) begin
      crc_encode = dass_pkg::CRC_BUSY;
    end else if (s.crc_pass) begin
      crc_encode = dass_pkg::CRC_GOOD;
    end else begin
      crc_encode = dass_pkg::CRC_FAIL;
    end
  endfunction : crc_encode

  // access decode
  assign status_read     = read_hit(acc, dass_pkg::SYS_STATUS_OFFSET);
  assign reset_req_write = write_hit(acc, dass_pkg::RESET_REQ_OFFSET);
  assign control_write   = write_hit(acc, dass_pkg::SYS_CONTROL_OFFSET);
  assign signature_match = (acc.wdata == dass_pkg::RESET_SIGNATURE);
  assign reset_live      = sys.in_reset || reset_req_reg;

  // reset-active flag: a live reset wins over the read clear,
  // so a read never hides a reset that is still in progress
  always_comb begin
    reset_seen_next = reset_seen_reg;
    if (reset_live) begin
      reset_seen_next = 1'h1;
    end else if (status_read) begin
      reset_seen_next = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reset_seen_reg <= 1'h0;
    end else begin
      reset_seen_reg <= reset_seen_next;
    end
  end

  // reset request: signature holds the system in reset, any other value
  // releases it; nothing on this side is reset by it
  always_comb begin
    reset_req_next = reset_req_reg;
    if (reset_req_write) begin
      reset_req_next = signature_match;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reset_req_reg <= 1'h0;
    end else begin
      reset_req_reg <= reset_req_next;
    end
  end

  // user-row-done pulse; ignored until the user-row key is decoded
  always_comb begin
    done_next = 1'h0;
    if (control_write && user_row_key_ok) begin
      done_next = acc.wdata[dass_pkg::UROW_DONE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      done_reg <= 1'h0;
    end else begin
      done_reg <= done_next;
    end
  end

  // system status byte; unused positions stay zero
  always_comb begin
    status_view = 8'h00;
    status_view[dass_pkg::RESET_ACTIVE_BIT] = reset_seen_reg;
    status_view[dass_pkg::ASLEEP_BIT]       = asleep(sys.sleep_mode);
    status_view[dass_pkg::NVM_READY_BIT]    = sys.nvm_program_ready;
    status_view[dass_pkg::UROW_READY_BIT]   = sys.user_row_program_ready;
    status_view[dass_pkg::LOCKED_BIT]       = sys.device_locked;
  end

  // scan status byte
  assign crc_code = crc_encode(sys);

  always_comb begin
    crc_view      = 8'h00;
    crc_view[2:0] = crc_code;
  end

  // reset request readback
  always_comb begin
    reset_req_view = 8'h00;
    reset_req_view[dass_pkg::RESET_REQ_BIT] = reset_req_reg;
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rdata_next = rdata_reg;
    if (acc.rd) begin
      unique case (acc.addr)
        dass_pkg::SYS_STATUS_OFFSET: rdata_next = status_view;
        dass_pkg::CRC_STATUS_OFFSET: rdata_next = crc_view;
        dass_pkg::RESET_REQ_OFFSET:  rdata_next = reset_req_view;
        default:                     rdata_next = 8'h00;
      endcase
    end
  end

  // read data holds until the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // one-cycle valid after each read strobe
  assign rvalid_next = acc.rd;

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_reg <= 1'h0;
    end else begin
      rvalid_reg <= rvalid_next;
    end
  end

  // outputs
  assign rdata                = rdata_reg;
  assign rvalid               = rvalid_reg;
  assign system_reset_request = reset_req_reg;
  assign user_row_write_done  = done_reg;

endmodule : dass_status
`default_nettype wire

// *** tb/dass_chk.sv ***
// Purpose: port checks
// Assumes: sync reset
// Notes: bind at foot
`timescale 1ns/100ps
`default_nettype none
module dass_chk (
  // watched ports
  input wire logic clock,
  input wire logic rst,
  input wire dass_pkg::dass_acc_t acc,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire dass_pkg::dass_sys_t sys,
  input wire logic user_row_key_ok,
  input wire logic system_reset_request,
  input wire logic user_row_write_done
);
  dass_pkg::dass_sys_t ps;
  logic go;
  always_ff @(posedge clock) ps <= sys;
  always_ff @(posedge clock) go <= user_row_key_ok && acc.wr && acc.addr == 8'h0A && acc.wdata[1];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_st; acc.rd && acc.addr == 8'h0B; endsequence
  sequence s_rq(v); acc.wr && acc.addr == 8'h08 && (acc.wdata == 8'h59) == v; endsequence
  sequence s_crc; acc.rd && acc.addr == 8'h0C; endsequence
  sequence s_calm; !sys.in_reset && !system_reset_request; endsequence
  a_lock_flag: assert property (s_st |=> rdata[0] == ps.device_locked) else $error("lock");
  a_sleep_flag: assert property (s_st |=> rdata[4] == (ps.sleep_mode != 2'h0)) else $error("sleep");
  a_nvm_flag: assert property (s_st |=> rdata[3] == ps.nvm_program_ready) else $error("nvm");
  a_urow_flag: assert property (s_st |=> rdata[2] == ps.user_row_program_ready) else $error("urow");
  a_reset_flag: assert property (sys.in_reset ##1 s_st |=> rdata[5]) else $error("rst");
  a_req_flag: assert property (system_reset_request ##1 s_st |=> rdata[5]) else $error("req flag");
  a_read_clear: assert property (s_st ##0 s_calm ##1 s_calm ##1 s_st |=> !rdata[5]) else $error("read clear");
  a_req_set: assert property (s_rq(1'h1) |=> system_reset_request) else $error("set");
  a_req_clear: assert property (s_rq(1'h0) |=> !system_reset_request) else $error("clr");
  a_urow_done: assert property (user_row_write_done == go) else $error("done");
  a_crc_onehot: assert property (s_crc |=> rdata[7:3] == 5'h00 && $onehot0(rdata[2:0])) else $error("crc");
  a_status_unused: assert property (s_st |=> rdata[7:6] == 2'h0 && !rdata[1]) else $error("unused");
endmodule : dass_chk
bind dass_status dass_chk dass_chk_inst (.clock, .rst, .acc, .rdata, .rvalid, .sys, .user_row_key_ok,
  .system_reset_request, .user_row_write_done);
`default_nettype wire

// *** tb/dass_dbg.sv ***
// Purpose: debugger model
// Assumes: one byte per access
// Notes: strobes move after rising edges
`timescale 1ns/100ps
`default_nettype none
module dass_dbg (
  // access port
  input wire logic clock,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output var dass_pkg::dass_acc_t acc
);
  initial acc = '0;
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [8:0] q);
    @(posedge clock);
    acc <= {~w, w, a, d};
    @(posedge clock);
    acc <= '0;
    #1 q = {rvalid, rdata};
  endtask : xfer
endmodule : dass_dbg
`default_nettype wire

// *** tb/dass_status_bench.sv ***
// Purpose: status block bench
// Assumes: 25 MHz clock
// Notes: rows, then hand cases
`timescale 1ns/100ps
`default_nettype none
module dass_status_bench;
  logic clock = 0, rst = 1, key = 0, rvalid, req, done;
  logic [7:0] rdata;
  logic [8:0] q;
  int n_fail = 0, n_tests = 0;
  dass_pkg::dass_sys_t sys = '0;
  dass_pkg::dass_acc_t acc;
  logic [24:0] rows [9] = '{{9'h008, 8'h0B, 8'h01}, {9'h060, 8'h0B, 8'h18}, {9'h090, 8'h0B, 8'h14},
    {9'h0C0, 8'h0B, 8'h10}, {9'h000, 8'h0C, 8'h00}, {9'h006, 8'h0C, 8'h01},
    {9'h005, 8'h0C, 8'h02}, {9'h004, 8'h0C, 8'h04}, {9'h008, 8'h20, 8'h00}};
  always #20 clock = ~clock;
  dass_dbg dass_dbg_inst (.clock, .rdata, .rvalid, .acc);
  dass_status dass_status_inst (.clock, .rst, .acc, .rdata, .rvalid, .sys, .user_row_key_ok(key),
    .system_reset_request(req), .user_row_write_done(done));
  task automatic chk(input logic [8:0] got, want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, e);
    dass_dbg_inst.xfer(1'h0, a, 8'h00, q);
    chk(q, {1'h1, e});
  endtask : rd
  task automatic wr(input logic [7:0] a, d, input logic [8:0] e);
    dass_dbg_inst.xfer(1'h1, a, d, q);
    chk({7'h00, done, req}, e);
  endtask : wr
  task automatic summarize;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    foreach (rows[i]) begin
      @(posedge clock) sys <= rows[i][24:16];
      rd(rows[i][15:8], rows[i][7:0]);
    end
    $display("rows done");
    @(posedge clock) sys <= 9'h100;
    rd(8'h0B, 8'h20);
    @(posedge clock) sys <= 9'h000;
    rd(8'h0B, 8'h20);
    rd(8'h0B, 8'h00);
    wr(8'h08, 8'h59, 9'h001);
    rd(8'h0B, 8'h20);
    rd(8'h08, 8'h01);
    wr(8'h08, 8'h00, 9'h000);
    rd(8'h0B, 8'h20);
    wr(8'h0B, 8'hFF, 9'h000);
    rd(8'h0B, 8'h00);
    wr(8'h0A, 8'h02, 9'h000);
    @(posedge clock) key <= 1'h1;
    wr(8'h0A, 8'h02, 9'h002);
    $display("hand cases done");
    wr(8'h08, 8'h59, 9'h001);
    @(posedge clock) rst <= 1'h1;
    sys <= 9'h008;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    #1 chk({rvalid, rdata}, 9'h000);
    chk({7'h00, done, req}, 9'h000);
    rd(8'h0B, 8'h01);
    rd(8'h08, 8'h00);
    $display("reset case done");
    summarize;
  end
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
endmodule : dass_status_bench
`default_nettype wire
